//--- hdl/ppt_pkg.sv
package ppt_pkg;
  // selectable port base addresses
  localparam logic [15:0] BASE_0278 = 16'h0278;
  localparam logic [15:0] BASE_0378 = 16'h0378;
  localparam logic [15:0] BASE_03BC = 16'h03bc;
  // register offsets from the base
  localparam logic [15:0] OFF_FIFO_A = 16'h0000;
  localparam logic [15:0] OFF_STATUS = 16'h0001;
  localparam logic [15:0] OFF_CONTROL = 16'h0002;
  localparam logic [15:0] OFF_ADDR_STB = 16'h0003;
  localparam logic [15:0] OFF_DATA_LO = 16'h0004;
  localparam logic [15:0] OFF_DATA_HI = 16'h0007;
  localparam logic [15:0] OFF_FIFO_400 = 16'h0400;
  localparam logic [15:0] OFF_CFG_B = 16'h0401;
  localparam logic [15:0] OFF_EXT_CTRL = 16'h0402;
  // control register bit positions
  localparam int CTRL_DIR = 5;
  localparam int CTRL_ACK_EN = 4;
  localparam int CTRL_SEL_IN = 3;
  localparam int CTRL_INIT = 2;
  localparam int CTRL_AUTO_FEED = 1;
  localparam int CTRL_STROBE = 0;
  // values after reset
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [5:0] EXT_CTRL_RESET = 6'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // mode field values
  localparam logic [2:0] MODE_ISA = 3'h0;
  localparam logic [2:0] MODE_PS2 = 3'h1;
  localparam logic [2:0] MODE_SPP_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG = 3'h7;
  // fifo shape: data byte plus address tag
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 32;
  typedef enum logic [1:0] {PS_IDLE = 2'b00, PS_SETUP = 2'b01, PS_STROBE = 2'b11, PS_RELEASE = 2'b10} port_state_e;
  typedef enum logic [1:0] {CYC_ADDR, CYC_DATA, CYC_DRAIN} cycle_e;
  typedef enum logic [3:0] {
    SEL_NONE, SEL_AFIFO, SEL_STATUS, SEL_CONTROL, SEL_ADDR_STB, SEL_DATA_STB,
    SEL_DFIFO, SEL_TEST_FIFO, SEL_CFG_A, SEL_CFG_B, SEL_EXT_CTRL
  } reg_sel_e;
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic perror;
    logic select;
    logic fault_n;
  } periph_status_s;
  typedef struct packed {
    logic aen;
    logic ior_n;
    logic iow_n;
    logic [15:0] addr;
    logic [7:0] data;
  } host_bus_s;
endpackage

//--- hdl/epp_ecp_port_registers.sv
// How it works
// RULE1: data lines drive out while direction bit is 0, float while 1.
// RULE2: acknowledge enable set routes ACK# onto the chosen interrupt line.
// RULE3: software writes zero to control bits 3, 1 and 0 in EPP mode.
// RULE4: init line follows control bit 2: 1 negates, 0 asserts.
// RULE5: EPP handshake alone generates strobe, auto-feed and select-in lines.
// RULE6: any access at offset 3 runs an address strobe cycle.
// RULE7: address strobe writes send the byte, reads return the peripheral byte.
// RULE8: any access to the data strobe register runs a data strobe cycle.
// RULE9: offsets 4 to 7 all decode to the data strobe register.
// RULE10: data strobe writes send the byte, reads return the peripheral byte.
// RULE11: extended control bits 7:5 hold the operating mode.
// RULE12: offset 400h maps by mode: fifos, test fifo or config A.
// RULE13: mode-restricted registers answer only when the mode field matches.
// RULE14: status, control and extended control answer in every mode; extended control is not decoded in EPP mode.
// RULE15: base address is 278h, 378h or 3BCh, offsets relative to it.
// RULE16: status bit 2 always reads as 1.
// RULE17: 3BCh base is not decoded in EPP mode.
// RULE18: strobe cycles follow the EPP wait handshake and hold the host.
// RULE19: control bits 7:6 ignore writes, read 0; writable bits reset to 0.

// synchronous fifo, first word visible on out_data
module sync_fifo #(
  parameter int WIDTH = ppt_pkg::FIFO_WIDTH,
  parameter int DEPTH = ppt_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // levels
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_push;
  logic do_pop;

  // refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sync_fifo depth must be a power of two of at least 2");
  end

  // flags and handshakes
  assign full = (count_reg == DEPTH[AW:0]);
  assign empty = (count_reg == '0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_reg];
  assign do_push = in_valid && !full;
  assign do_pop = out_ready && !empty;

  // storage
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // sync_fifo

module epp_ecp_port_registers #(
  parameter int FIFO_DEPTH = ppt_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host i/o bus
  input wire ppt_pkg::host_bus_s host_bus,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe_n,
  output logic io_wait_oe_n,
  // straps
  input wire logic [1:0] base_select,
  input wire logic epp_mode,
  input wire logic irq_select,
  // interrupts
  output logic irq_line_a,
  output logic irq_line_b,
  // parallel port
  input wire logic [7:0] port_data_lines_in,
  output logic [7:0] port_data_lines_out,
  output logic port_data_lines_oe_n,
  input wire ppt_pkg::periph_status_s periph,
  output logic strobe_n,
  output logic autofd_n,
  output logic selectin_n,
  output logic init_n
);
  logic [1:0] rst_pipe;
  logic rst_n;
  ppt_pkg::host_bus_s hb_meta;
  ppt_pkg::host_bus_s hb_sync;
  ppt_pkg::periph_status_s ps_meta;
  ppt_pkg::periph_status_s ps_sync;
  logic [7:0] pin_data_meta;
  logic [7:0] pin_data_sync;
  logic [3:0] cfg_meta;
  logic [3:0] cfg_sync;
  logic rd_prev;
  logic wr_prev;
  logic go_rd;
  logic go_wr;
  logic go_any;
  logic cfg_epp;
  ppt_pkg::reg_sel_e acc_sel;
  logic [5:0] ctrl_reg;
  logic [5:0] ext_ctrl_reg;
  logic [2:0] mode;
  logic [7:0] cfg_a_reg;
  logic [7:0] cfg_b_reg;
  logic [7:0] rd_data_reg;
  logic host_oe_reg;
  logic push_pending_reg;
  logic [ppt_pkg::FIFO_WIDTH-1:0] push_word_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [ppt_pkg::FIFO_WIDTH-1:0] fifo_out_data;
  logic fifo_full;
  logic fifo_empty;
  logic is_fifo_sel;
  logic host_pop;
  logic drain_start;
  logic epp_go;
  logic epp_read_done;
  ppt_pkg::port_state_e port_state_reg;
  ppt_pkg::cycle_e cycle_reg;
  logic cyc_read_reg;
  logic tag_reg;
  logic wait_reg;
  logic [7:0] pin_data_out_reg;
  logic ack_irq;
  logic active;

  // register decode from base, offset and mode field
  function automatic ppt_pkg::reg_sel_e decode(input logic [15:0] a, input logic [1:0] bsel,
                                              input logic epp, input logic [2:0] md);
    logic [15:0] base;
    logic [15:0] off;
    decode = ppt_pkg::SEL_NONE;
    if (bsel == 2'h0) begin
      base = ppt_pkg::BASE_0278; // see RULE15
    end else if (bsel == 2'h1) begin
      base = ppt_pkg::BASE_0378;
    end else begin
      base = ppt_pkg::BASE_03BC;
    end
    off = a - base;
    if (bsel == 2'h3 || (epp && bsel == 2'h2)) begin
      decode = ppt_pkg::SEL_NONE; // see RULE17
    end else if (off == ppt_pkg::OFF_STATUS) begin
      decode = ppt_pkg::SEL_STATUS; // see RULE14
    end else if (off == ppt_pkg::OFF_CONTROL) begin
      decode = ppt_pkg::SEL_CONTROL;
    end else if (epp) begin
      if (off == ppt_pkg::OFF_ADDR_STB) begin
        decode = ppt_pkg::SEL_ADDR_STB;
      end else if (off >= ppt_pkg::OFF_DATA_LO && off <= ppt_pkg::OFF_DATA_HI) begin
        decode = ppt_pkg::SEL_DATA_STB; // see RULE9
      end
    end else if (off == ppt_pkg::OFF_EXT_CTRL) begin
      decode = ppt_pkg::SEL_EXT_CTRL;
    end else if (off == ppt_pkg::OFF_FIFO_A && md == ppt_pkg::MODE_ECP) begin
      decode = ppt_pkg::SEL_AFIFO; // see RULE13
    end else if (off == ppt_pkg::OFF_FIFO_400) begin
      if (md == ppt_pkg::MODE_SPP_FIFO || md == ppt_pkg::MODE_ECP) begin
        decode = ppt_pkg::SEL_DFIFO; // see RULE12
      end else if (md == ppt_pkg::MODE_TEST) begin
        decode = ppt_pkg::SEL_TEST_FIFO;
      end else if (md == ppt_pkg::MODE_CFG) begin
        decode = ppt_pkg::SEL_CFG_A;
      end
    end else if (off == ppt_pkg::OFF_CFG_B && md == ppt_pkg::MODE_CFG) begin
      decode = ppt_pkg::SEL_CFG_B;
    end
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // two-flop synchronisers for every pin input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_meta <= '1;
      hb_sync <= '1;
      ps_meta <= '1;
      ps_sync <= '1;
      pin_data_meta <= 8'h00;
      pin_data_sync <= 8'h00;
      cfg_meta <= 4'h0;
      cfg_sync <= 4'h0;
    end else begin
      hb_meta <= host_bus;
      hb_sync <= hb_meta;
      ps_meta <= periph;
      ps_sync <= ps_meta;
      pin_data_meta <= port_data_lines_in;
      pin_data_sync <= pin_data_meta;
      cfg_meta <= {base_select, epp_mode, irq_select};
      cfg_sync <= cfg_meta;
    end
  end

  // falling edges of the host strobes start an access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
    end else begin
      rd_prev <= hb_sync.ior_n;
      wr_prev <= hb_sync.iow_n;
    end
  end
  assign go_rd = rd_prev && !hb_sync.ior_n && !hb_sync.aen;
  assign go_wr = wr_prev && !hb_sync.iow_n && !hb_sync.aen;
  assign go_any = go_rd || go_wr;
  assign cfg_epp = cfg_sync[1];
  assign mode = ext_ctrl_reg[5:3]; // see RULE11
  assign acc_sel = decode(hb_sync.addr, cfg_sync[3:2], cfg_epp, mode);
  assign is_fifo_sel = (acc_sel == ppt_pkg::SEL_AFIFO) || (acc_sel == ppt_pkg::SEL_DFIFO) ||
                       (acc_sel == ppt_pkg::SEL_TEST_FIFO);
  assign host_pop = go_rd && is_fifo_sel;
  assign epp_go = go_any && port_state_reg == ppt_pkg::PS_IDLE &&
                  (acc_sel == ppt_pkg::SEL_ADDR_STB || acc_sel == ppt_pkg::SEL_DATA_STB);
  assign epp_read_done = port_state_reg == ppt_pkg::PS_STROBE && ps_sync.busy &&
                         cyc_read_reg && cycle_reg != ppt_pkg::CYC_DRAIN;

  // register writes, read data and host bus drive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= ppt_pkg::CTRL_RESET; // see RULE19
      ext_ctrl_reg <= ppt_pkg::EXT_CTRL_RESET;
      cfg_a_reg <= ppt_pkg::CFG_RESET;
      cfg_b_reg <= ppt_pkg::CFG_RESET;
      rd_data_reg <= 8'h00;
      host_oe_reg <= 1'b0;
    end else begin
      if (go_wr) begin
        if (acc_sel == ppt_pkg::SEL_CONTROL) begin
          ctrl_reg <= hb_sync.data[5:0]; // see RULE19
        end else if (acc_sel == ppt_pkg::SEL_EXT_CTRL) begin
          ext_ctrl_reg <= hb_sync.data[7:2]; // see RULE11
        end else if (acc_sel == ppt_pkg::SEL_CFG_A) begin
          cfg_a_reg <= hb_sync.data;
        end else if (acc_sel == ppt_pkg::SEL_CFG_B) begin
          cfg_b_reg <= hb_sync.data;
        end
      end
      if (go_rd) begin
        case (acc_sel)
          ppt_pkg::SEL_STATUS: rd_data_reg <= {!ps_sync.busy, ps_sync.ack_n, ps_sync.perror,
                                                ps_sync.select, ps_sync.fault_n, 1'b1, 2'b00}; // see RULE16
          ppt_pkg::SEL_CONTROL: rd_data_reg <= {2'b00, ctrl_reg}; // see RULE19
          ppt_pkg::SEL_EXT_CTRL: rd_data_reg <= {ext_ctrl_reg, fifo_full, fifo_empty};
          ppt_pkg::SEL_CFG_A: rd_data_reg <= cfg_a_reg;
          ppt_pkg::SEL_CFG_B: rd_data_reg <= cfg_b_reg;
          ppt_pkg::SEL_AFIFO, ppt_pkg::SEL_DFIFO, ppt_pkg::SEL_TEST_FIFO: begin
            rd_data_reg <= fifo_out_valid ? fifo_out_data[7:0] : 8'h00;
          end
          default: rd_data_reg <= rd_data_reg;
        endcase
      end else if (epp_read_done) begin
        rd_data_reg <= pin_data_sync; // see RULE7
      end
      if (go_rd && acc_sel != ppt_pkg::SEL_NONE) begin
        host_oe_reg <= 1'b1;
      end else if (hb_sync.ior_n) begin
        host_oe_reg <= 1'b0; // see RULE14
      end
    end
  end
  assign host_data_bus_out = rd_data_reg;
  assign host_data_bus_oe_n = !host_oe_reg;

  // host writes into the fifo wait for room
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      push_pending_reg <= 1'b0;
      push_word_reg <= '0;
    end else if (go_wr && is_fifo_sel) begin
      push_pending_reg <= 1'b1;
      push_word_reg <= {acc_sel == ppt_pkg::SEL_AFIFO, hb_sync.data};
    end else if (push_pending_reg && fifo_in_ready) begin
      push_pending_reg <= 1'b0;
    end
  end

  // transmit fifo between host and port
  sync_fifo #(
    .WIDTH(ppt_pkg::FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) sync_fifo_inst (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_pending_reg),
    .in_ready(fifo_in_ready),
    .in_data(push_word_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .full(fifo_full),
    .empty(fifo_empty)
  );
  assign drain_start = port_state_reg == ppt_pkg::PS_IDLE && !cfg_epp && fifo_out_valid && !host_pop &&
                       !ctrl_reg[ppt_pkg::CTRL_DIR] &&
                       (mode == ppt_pkg::MODE_SPP_FIFO || mode == ppt_pkg::MODE_ECP);
  assign fifo_out_ready = host_pop || drain_start;

  // port handshake: setup, strobe until busy, release until not busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_state_reg <= ppt_pkg::PS_IDLE;
      cycle_reg <= ppt_pkg::CYC_ADDR;
      cyc_read_reg <= 1'b0;
      tag_reg <= 1'b0;
      wait_reg <= 1'b0;
      pin_data_out_reg <= 8'h00;
    end else begin
      case (port_state_reg)
        ppt_pkg::PS_IDLE: begin
          if (epp_go) begin
            cycle_reg <= (acc_sel == ppt_pkg::SEL_ADDR_STB) ? ppt_pkg::CYC_ADDR : ppt_pkg::CYC_DATA; // see RULE6
            cyc_read_reg <= go_rd;
            wait_reg <= 1'b1; // see RULE18
            if (go_wr) begin
              pin_data_out_reg <= hb_sync.data; // see RULE10
            end
            port_state_reg <= ppt_pkg::PS_SETUP; // see RULE8
          end else if (drain_start) begin
            cycle_reg <= ppt_pkg::CYC_DRAIN;
            cyc_read_reg <= 1'b0;
            pin_data_out_reg <= fifo_out_data[7:0];
            tag_reg <= fifo_out_data[8];
            port_state_reg <= ppt_pkg::PS_SETUP;
          end
        end
        ppt_pkg::PS_SETUP: port_state_reg <= ppt_pkg::PS_STROBE;
        ppt_pkg::PS_STROBE: begin
          if (ps_sync.busy) begin
            port_state_reg <= ppt_pkg::PS_RELEASE; // see RULE18
          end
        end
        ppt_pkg::PS_RELEASE: begin
          if (!ps_sync.busy) begin
            port_state_reg <= ppt_pkg::PS_IDLE;
            wait_reg <= 1'b0;
          end
        end
        default: port_state_reg <= ppt_pkg::PS_IDLE;
      endcase
    end
  end
  assign io_wait_oe_n = !(wait_reg || (push_pending_reg && !fifo_in_ready));

  // port control lines: handshake in EPP, control bits and fifo drain cycles otherwise
  assign active = port_state_reg != ppt_pkg::PS_IDLE;
  always_comb begin
    if (cfg_epp) begin
      strobe_n = !(active && !cyc_read_reg); // see RULE5
      autofd_n = !(port_state_reg == ppt_pkg::PS_STROBE && cycle_reg == ppt_pkg::CYC_DATA);
      selectin_n = !(port_state_reg == ppt_pkg::PS_STROBE && cycle_reg == ppt_pkg::CYC_ADDR);
    end else begin
      strobe_n = !(ctrl_reg[ppt_pkg::CTRL_STROBE] ||
                   (cycle_reg == ppt_pkg::CYC_DRAIN && port_state_reg == ppt_pkg::PS_STROBE));
      autofd_n = !(ctrl_reg[ppt_pkg::CTRL_AUTO_FEED] || (cycle_reg == ppt_pkg::CYC_DRAIN && active && tag_reg));
      selectin_n = !ctrl_reg[ppt_pkg::CTRL_SEL_IN];
    end
  end
  assign init_n = ctrl_reg[ppt_pkg::CTRL_INIT]; // see RULE4
  assign port_data_lines_out = pin_data_out_reg;
  assign port_data_lines_oe_n = ctrl_reg[ppt_pkg::CTRL_DIR]; // see RULE1

  // acknowledge interrupt to the strapped line
  assign ack_irq = ctrl_reg[ppt_pkg::CTRL_ACK_EN] && !ps_sync.ack_n; // see RULE2
  assign irq_line_a = ack_irq && !cfg_sync[0];
  assign irq_line_b = ack_irq && cfg_sync[0];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_epp_go(ppt_pkg::reg_sel_e s);
    go_any && acc_sel == s && port_state_reg == ppt_pkg::PS_IDLE;
  endsequence
  sequence s_strobe_low(logic line_n);
    ##2 !line_n;
  endsequence
  property p_dir;
    !ctrl_reg[ppt_pkg::CTRL_DIR] |-> !port_data_lines_oe_n;
  endproperty
  a_dir: assert property (p_dir) else $error("data lines not driven in forward direction"); // see RULE1
  property p_irq_off;
    !ctrl_reg[ppt_pkg::CTRL_ACK_EN] |-> !irq_line_a && !irq_line_b;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt with enable clear"); // see RULE2
  property p_irq_on;
    ctrl_reg[ppt_pkg::CTRL_ACK_EN] && !ps_sync.ack_n |-> irq_line_a != irq_line_b;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("acknowledge interrupt missing"); // see RULE2
  property p_init;
    go_wr && acc_sel == ppt_pkg::SEL_CONTROL |=> init_n == $past(hb_sync.data[2]);
  endproperty
  a_init: assert property (p_init) else $error("init line does not follow control bit"); // see RULE4
  property p_epp_idle;
    cfg_epp && !active |-> strobe_n && autofd_n && selectin_n;
  endproperty
  a_epp_idle: assert property (p_epp_idle) else $error("handshake line active while idle"); // see RULE5
  property p_addr_cycle;
    s_epp_go(ppt_pkg::SEL_ADDR_STB) |-> s_strobe_low(selectin_n);
  endproperty
  a_addr_cycle: assert property (p_addr_cycle) else $error("address strobe not generated"); // see RULE6
  property p_data_cycle;
    s_epp_go(ppt_pkg::SEL_DATA_STB) |-> s_strobe_low(autofd_n);
  endproperty
  a_data_cycle: assert property (p_data_cycle) else $error("data strobe not generated"); // see RULE8
  property p_wr_strobe;
    epp_go && go_wr |-> s_strobe_low(strobe_n);
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("strobe not generated on write cycle"); // see RULE5
  property p_wr_data;
    s_epp_go(ppt_pkg::SEL_DATA_STB) ##0 go_wr |=> port_data_lines_out == $past(hb_sync.data);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("written byte not on data lines"); // see RULE10
  property p_hold;
    port_state_reg == ppt_pkg::PS_STROBE && !ps_sync.busy && cycle_reg != ppt_pkg::CYC_DRAIN
      |-> !io_wait_oe_n ##1 port_state_reg == ppt_pkg::PS_STROBE;
  endproperty
  a_hold: assert property (p_hold) else $error("strobe dropped before peripheral wait"); // see RULE18
  property p_status;
    go_rd && acc_sel == ppt_pkg::SEL_STATUS |=> rd_data_reg[2] && !host_data_bus_oe_n;
  endproperty
  a_status: assert property (p_status) else $error("status bit 2 not one"); // see RULE16
  property p_block;
    go_any && acc_sel == ppt_pkg::SEL_NONE |=> host_data_bus_oe_n;
  endproperty
  a_block: assert property (p_block) else $error("unmapped or blocked register answered"); // see RULE14
  property p_ctrl_rsv;
    go_rd && acc_sel == ppt_pkg::SEL_CONTROL |=> rd_data_reg[7:6] == 2'b00;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved control bits not zero"); // see RULE19
endmodule // epp_ecp_port_registers

//--- testbench/epp_periph_model.sv
// epp peripheral: answers address and data strobes over the wait line
module epp_periph_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic autofd_n,
  input wire logic selectin_n,
  input wire logic oe_n,
  input wire logic [7:0] dev_data,
  // test control
  input wire logic [7:0] reply,
  input wire logic [3:0] delay,
  // peripheral side
  output logic busy,
  output logic [7:0] din,
  output logic [7:0] seen,
  output logic addr_kind,
  output int n_cyc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  initial begin
    busy = 1'b0;
    cnt = 4'h0;
    n_cyc = 0;
    seen = 8'h00;
    addr_kind = 1'b0;
  end
  // raise wait after delay cycles, drop it once the strobe ends
  always @(posedge clk) begin
    if (!autofd_n || !selectin_n) begin
      cnt <= cnt + 4'h1;
      if (cnt == delay && !busy) begin
        busy <= 1'b1;
        seen <= dev_data;
        addr_kind <= !selectin_n;
        n_cyc <= n_cyc + 1;
      end
    end else begin
      cnt <= 4'h0;
      busy <= 1'b0;
    end
  end
  // wire level: device byte, reply while answering, else inverted junk
  assign din = !oe_n ? dev_data : (busy ? reply : ~reply);
endmodule // epp_periph_model

//--- testbench/epp_ecp_port_registers_tb.sv
module epp_ecp_port_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, irq_sel, epp, ack_n, busy, oe_n, kind, got, irq_a, irq_b;
  logic [1:0] bsel;
  logic [7:0] hout, pout, din, seen, reply, q;
  logic [3:0] dly;
  logic [15:0] base;
  logic hoe_n, wait_n, stb_n, afd_n, sel_n, init_n;
  int n_cyc, num_errors, n_checks, cyc;
  ppt_pkg::host_bus_s hb;
  wire ppt_pkg::periph_status_s ps = {busy, ack_n, 1'b0, 1'b1, 1'b1};
  epp_ecp_port_registers #(.FIFO_DEPTH(32)) epp_ecp_port_registers_inst (.clk(clk), .nrst(nrst), .host_bus(hb),
    .host_data_bus_out(hout), .host_data_bus_oe_n(hoe_n), .io_wait_oe_n(wait_n), .base_select(bsel),
    .epp_mode(epp), .irq_select(irq_sel), .irq_line_a(irq_a), .irq_line_b(irq_b), .port_data_lines_in(din),
    .port_data_lines_out(pout), .port_data_lines_oe_n(oe_n), .periph(ps), .strobe_n(stb_n), .autofd_n(afd_n),
    .selectin_n(sel_n), .init_n(init_n));
  epp_periph_model epp_periph_model_inst (.clk(clk), .autofd_n(afd_n), .selectin_n(sel_n), .oe_n(oe_n),
    .dev_data(pout), .reply(reply), .delay(dly), .busy(busy), .din(din), .seen(seen), .addr_kind(kind),
    .n_cyc(n_cyc));
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic chk(input logic [9:0] g, input logic [9:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  // one host cycle; holds the strobe until the wait pin lets go and, on reads, the data bus is driven, for 200 ticks at most
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n;
    hb.addr = a;
    hb.data = d;
    hb.aen = 1'b0;
    tick(4);
    if (wr) hb.iow_n = 1'b0;
    else hb.ior_n = 1'b0;
    tick(6);
    for (n = 0; n < 200 && (wait_n !== 1'b1 || (!wr && hoe_n !== 1'b0)); n++) tick(1);
    got = (n < 200);
    q = hout;
    hb = '{1'b1, 1'b1, 1'b1, 16'h0000, 8'h00};
    tick(4);
  endtask
  // verdict
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic t_control;
    chk({init_n, oe_n}, 8'h00, "reset lines");
    acc(0, base + 16'h2, 8'h00);
    chk(q, 8'h00, "control reset");
    acc(1, base + 16'h2, 8'hf4);
    acc(0, base + 16'h2, 8'h00);
    chk(q, 8'h34, "control reserved");
    chk({init_n, oe_n}, 8'h03, "init and dir");
    chk({stb_n, afd_n, sel_n}, 8'h07, "auto lines");
    acc(0, base + 16'h1, 8'h00);
    chk(q[2:0], 8'h04, "status flag");
  endtask
  task automatic t_irq(input logic s);
    irq_sel = s;
    acc(1, base + 16'h2, 8'h14);
    ack_n = 1'b0;
    tick(5);
    chk({irq_a, irq_b}, s ? 8'h01 : 8'h02, "irq on");
    acc(1, base + 16'h2, 8'h04);
    chk({irq_a, irq_b}, 8'h00, "irq masked");
    ack_n = 1'b1;
  endtask
  task automatic t_epp(input logic [15:0] off, input logic [7:0] b, input logic [3:0] dl);
    int n0;
    n0 = n_cyc;
    dly = dl;
    acc(1, base + 16'h2, 8'h04);
    acc(1, base + off, b);
    chk({got, kind, seen}, {off == 16'h3, b} | 10'h200, "strobe write");
    reply = ~b;
    acc(1, base + 16'h2, 8'h24);
    acc(0, base + off, 8'h00);
    chk({got, q}, {1'b1, ~b}, "strobe read");
    chk(10'(n_cyc - n0), 8'h02, "cycle count");
  endtask
  task automatic t_ecp;
    bsel = 2'h2;
    base = ppt_pkg::BASE_03BC;
    tick(6);
    acc(0, base + 16'h2, 8'h00);
    chk(got, 8'h00, "epp high base");
    epp = 1'b0;
    tick(8);
    acc(1, base + ppt_pkg::OFF_EXT_CTRL, 8'he0);
    acc(0, base + ppt_pkg::OFF_EXT_CTRL, 8'h00);
    chk(q, 8'he1, "mode read");
    acc(1, base + ppt_pkg::OFF_CFG_B, 8'h5a);
    acc(1, base + ppt_pkg::OFF_FIFO_400, 8'ha5);
    acc(0, base + ppt_pkg::OFF_CFG_B, 8'h00);
    chk({got, q}, 9'h15a, "cfg b");
    acc(0, base + ppt_pkg::OFF_FIFO_400, 8'h00);
    chk({got, q}, 9'h1a5, "cfg a");
    acc(1, base + ppt_pkg::OFF_EXT_CTRL, 8'hc0);
    acc(1, base + ppt_pkg::OFF_FIFO_400, 8'h3c);
    acc(0, base + ppt_pkg::OFF_EXT_CTRL, 8'h00);
    chk(q, 8'hc0, "test fifo filled");
    acc(0, base + ppt_pkg::OFF_FIFO_400, 8'h00);
    chk({got, q}, 9'h13c, "test fifo pop");
    acc(1, base + ppt_pkg::OFF_EXT_CTRL, 8'h20);
    acc(0, base + ppt_pkg::OFF_CFG_B, 8'h00);
    chk(got, 8'h00, "cfg b blocked");
    acc(0, base + ppt_pkg::OFF_CONTROL, 8'h00);
    chk(got, 8'h01, "control open");
  endtask
  // main sequence
  initial begin
    hb = '{1'b1, 1'b1, 1'b1, 16'h0000, 8'h00};
    {nrst, irq_sel, epp, ack_n, bsel, reply, dly, base, num_errors, n_checks, cyc} = 0;
    epp = 1'b1;
    ack_n = 1'b1;
    bsel = 2'h1;
    base = ppt_pkg::BASE_0378;
    tick(12);
    nrst = 1'b1;
    tick(8);
    t_control();
    t_irq(0);
    t_irq(1);
    for (int o = 3; o < 8; o++) t_epp(16'(o), 8'(8'h31 * o), 4'(o & 5));
    t_ecp();
    close_out();
  end
endmodule // epp_ecp_port_registers_tb
